/* shared/pcintu_pkg.sv */
// constants for the pin change interrupt unit
package pcintu_pkg;
  // group count and widths
  localparam int NUM_GRP = 3;
  localparam int GRP0_W  = 8;
  localparam int GRP1_W  = 7;
  localparam int GRP2_W  = 8;
  localparam int DATA_W  = 32;
  localparam int IDX_W   = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MASK0   = 8'h6B;
  localparam logic [IDX_W-1:0] IDX_MASK1   = 8'h6C;
  localparam logic [IDX_W-1:0] IDX_MASK2   = 8'h6D;
  localparam logic [IDX_W-1:0] IDX_GRP_EN  = 8'h70;
  localparam logic [IDX_W-1:0] IDX_GRP_FLG = 8'h71;
  localparam logic [IDX_W-1:0] IDX_CORE_ST = 8'h72;
  localparam logic [IDX_W-1:0] IDX_EVT_ST  = 8'h73;
  localparam logic [IDX_W-1:0] IDX_EVT_CLR = 8'h74;
  localparam logic [IDX_W-1:0] IDX_EVT_EN  = 8'h75;

  // field positions
  localparam int GRP0_BIT = 0;
  localparam int GRP1_BIT = 1;
  localparam int GRP2_BIT = 2;
  localparam int GIE_BIT  = 7;

  // reset values
  localparam logic [GRP0_W-1:0]  MASK0_RST = 8'h00;
  localparam logic [GRP1_W-1:0]  MASK1_RST = 7'h00;
  localparam logic [GRP2_W-1:0]  MASK2_RST = 8'h00;
  localparam logic [NUM_GRP-1:0] GRP_RST   = 3'h0;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;
endpackage

/* core/pcintu_core.sv */
// pin change interrupt unit: pin watchers, group flags and bus registers
// register map, as word index and byte address (four times the index)
//   0x6B  0x1AC  group 0 pin mask, eight bits, read and write
//   0x6C  0x1B0  group 1 pin mask, seven bits, top bit reads zero
//   0x6D  0x1B4  group 2 pin mask, eight bits, read and write
//   0x70  0x1C0  group enables, bit g for group g
//   0x71  0x1C4  group flags, read; writing a one clears that flag
//   0x72  0x1C8  core status, global interrupt enable in bit 7
//   0x73  0x1CC  event status, sticky copy of the group flags
//   0x74  0x1D0  event clear, write only, reads zero
//   0x75  0x1D4  event enable, same layout as event status
//   any other index reads zero and ignores writes
//   any address with bits above the index set misses every register
//
// bus behaviour
//   the slave never stretches a transfer: hreadyout is tied high
//   the response is always okay, even for unmapped addresses
//   a transfer is taken when select, ready and a NONSEQ or SEQ type meet
//   write data is taken one edge later, in the data phase
//   read data is sampled in the address phase and held in a register
//   so a read right after a write to the same register sees the old value
//   hrdata keeps its value until the next read address phase
//   transfer size is not checked; whole words are assumed
//   byte lanes above the register width are ignored on writes
//
// pin behaviour
//   every pin passes two flops before any logic looks at it
//   a third flop keeps the previous synchronised sample
//   a pin differs from its previous sample for exactly one cycle per edge
//   the mask selects which pins may raise the group's change strobe
//   a cleared mask bit blocks that pin completely
//   the group enable does not gate the flag, only the vector request
//   a pulse shorter than one clock period may be missed entirely
//   changes in consecutive cycles are each seen as a change
//   a change at the pin shows in the flag three edges later
//   after reset the synchronisers hold zero, so a pin that is already
//   high looks like a change shortly after release; with all masks
//   at zero after reset nothing is flagged unless software unmasks early
//
// flag behaviour
//   a group flag is set by any watched change of its group
//   it is cleared by the core's acknowledge when the vector is taken
//   it is also cleared by writing a one to its bit in the flag register
//   writing a zero leaves the flag alone
//   when a change and a clear meet in one cycle the change wins,
//   so no pin event is lost to a late acknowledge
//   the event status bits follow the same set and clear rules,
//   cleared through the event clear register instead
//
// request behaviour
//   a group request is its flag and its enable and the global enable
//   requests are combinational from registers, so they settle early
//   a pending flag keeps its request high until the flag, its group enable or the global enable is cleared
//   dropping the global enable hides all requests but keeps the flags
//   the system interrupt is high while any enabled event bit is set
//
// limitations
//   the acknowledge is assumed to be a single-cycle pulse on this clock
//   two acknowledges for the same group in a row clear it only once
//   the core status register only holds the global enable bit here
//   no wake-up from a stopped clock: detection needs the clock running
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

// one pin group: synchroniser, previous sample and masked change detect
module pcintu_group
  import pcintu_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // pins and mask
  input  wire logic [W-1:0] pins,
  input  wire logic [W-1:0] mask,
  // any watched pin changed
  output logic              change
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;

  // two-flop synchroniser then one sample of history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= pins;
      sync <= meta;
      prev <= sync;
    end
  end

  // cleared mask bits never raise a change
  assign change = |((sync ^ prev) & mask);
endmodule

// top of the unit with its AHB-Lite slave
module pcintu_core
  import pcintu_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [DATA_W-1:0]  haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [DATA_W-1:0]  hwdata,
  output logic [DATA_W-1:0]       hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // watched pins
  input  wire logic [GRP0_W-1:0]  watched_pins_group0,
  input  wire logic [GRP1_W-1:0]  watched_pins_group1,
  input  wire logic [GRP2_W-1:0]  watched_pins_group2,
  // core vector interface
  output logic [NUM_GRP-1:0]      group_vector_req,
  input  wire logic [NUM_GRP-1:0] group_vector_ack,
  // system interrupt
  output logic                    irq
);
  // register state; masks, enables, flags and event bits
  logic [GRP0_W-1:0]  pin_watch_mask_group0;
  logic [GRP1_W-1:0]  pin_watch_mask_group1;
  logic [GRP2_W-1:0]  pin_watch_mask_group2;
  logic [NUM_GRP-1:0] change_group_enable;
  logic [NUM_GRP-1:0] change_group_flags;
  logic               global_int_enable;
  logic [NUM_GRP-1:0] event_status;
  logic [NUM_GRP-1:0] event_enable;
  logic               wr_pend;
  logic [IDX_W-1:0]   wr_idx;
  logic [NUM_GRP-1:0] grp_change;

  // pin groups
  pcintu_group #(.W(GRP0_W)) u_grp0
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (watched_pins_group0),
    .mask    (pin_watch_mask_group0),
    .change  (grp_change[GRP0_BIT])
  );
  pcintu_group #(.W(GRP1_W)) u_grp1
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (watched_pins_group1),
    .mask    (pin_watch_mask_group1),
    .change  (grp_change[GRP1_BIT])
  );
  pcintu_group #(.W(GRP2_W)) u_grp2
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (watched_pins_group2),
    .mask    (pin_watch_mask_group2),
    .change  (grp_change[GRP2_BIT])
  );

  // bus address phase decode
  wire             addr_ok  = (haddr[DATA_W-1:IDX_W+2] == '0);
  wire [IDX_W-1:0] addr_idx = haddr[IDX_W+1:2];
  wire             xfer     = hsel & hready & htrans[1];
  wire             rd_req   = xfer & ~hwrite;

  // data phase write strobes
  wire wr_mask0 = wr_pend & (wr_idx == IDX_MASK0);
  wire wr_mask1 = wr_pend & (wr_idx == IDX_MASK1);
  wire wr_mask2 = wr_pend & (wr_idx == IDX_MASK2);
  wire wr_gen   = wr_pend & (wr_idx == IDX_GRP_EN);
  wire wr_gflg  = wr_pend & (wr_idx == IDX_GRP_FLG);
  wire wr_core  = wr_pend & (wr_idx == IDX_CORE_ST);
  wire wr_eclr  = wr_pend & (wr_idx == IDX_EVT_CLR);
  wire wr_een   = wr_pend & (wr_idx == IDX_EVT_EN);

  // write-one clears; a new change wins over a clear
  wire [NUM_GRP-1:0] flag_clr =
    (wr_gflg ? hwdata[NUM_GRP-1:0] : '0) | group_vector_ack;
  wire [NUM_GRP-1:0] next_flags =
    (change_group_flags & ~flag_clr) | grp_change;
  wire [NUM_GRP-1:0] evt_clr = wr_eclr ? hwdata[NUM_GRP-1:0] : '0;
  wire [NUM_GRP-1:0] next_event = (event_status & ~evt_clr) | grp_change;

  // read selection; unused and reserved bits read zero
  wire [DATA_W-1:0] rd_data =
    !addr_ok                   ? '0 :
    (addr_idx == IDX_MASK0)    ? {{(DATA_W-GRP0_W){1'b0}}, pin_watch_mask_group0} :
    (addr_idx == IDX_MASK1)    ? {{(DATA_W-GRP1_W){1'b0}}, pin_watch_mask_group1} :
    (addr_idx == IDX_MASK2)    ? {{(DATA_W-GRP2_W){1'b0}}, pin_watch_mask_group2} :
    (addr_idx == IDX_GRP_EN)   ? {{(DATA_W-NUM_GRP){1'b0}}, change_group_enable} :
    (addr_idx == IDX_GRP_FLG)  ? {{(DATA_W-NUM_GRP){1'b0}}, change_group_flags} :
    (addr_idx == IDX_CORE_ST)  ? {{(DATA_W-GIE_BIT-1){1'b0}}, global_int_enable,
                                  {GIE_BIT{1'b0}}} :
    (addr_idx == IDX_EVT_ST)   ? {{(DATA_W-NUM_GRP){1'b0}}, event_status} :
    (addr_idx == IDX_EVT_EN)   ? {{(DATA_W-NUM_GRP){1'b0}}, event_enable} :
    '0;

  // bus answers: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // vector requests and system interrupt
  assign group_vector_req =
    change_group_flags & change_group_enable & {NUM_GRP{global_int_enable}};
  assign irq = |(event_status & event_enable);

  // capture write address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
    end
    else
    begin
      wr_pend <= xfer & hwrite & addr_ok;
      wr_idx  <= addr_idx;
    end
  end

  // read data register, loaded in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (rd_req)
      hrdata <= rd_data;
  end

  // mask registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_watch_mask_group0 <= MASK0_RST;
      pin_watch_mask_group1 <= MASK1_RST;
      pin_watch_mask_group2 <= MASK2_RST;
    end
    else
    begin
      if (wr_mask0)
        pin_watch_mask_group0 <= hwdata[GRP0_W-1:0];
      if (wr_mask1)
        pin_watch_mask_group1 <= hwdata[GRP1_W-1:0];
      if (wr_mask2)
        pin_watch_mask_group2 <= hwdata[GRP2_W-1:0];
    end
  end

  // group enables and global enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      change_group_enable <= GRP_RST;
      global_int_enable   <= 1'b0;
      event_enable        <= GRP_RST;
    end
    else
    begin
      if (wr_gen)
        change_group_enable <= hwdata[NUM_GRP-1:0];
      if (wr_core)
        global_int_enable <= hwdata[GIE_BIT];
      if (wr_een)
        event_enable <= hwdata[NUM_GRP-1:0];
    end
  end

  // sticky group flags and event status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      change_group_flags <= GRP_RST;
      event_status       <= GRP_RST;
    end
    else
    begin
      change_group_flags <= next_flags;
      event_status       <= next_event;
    end
  end
endmodule

`default_nettype wire

/* tb/pcintu_core_sva.sv */
// port checker for the pin change interrupt unit
`timescale 1ns/100ps
`default_nettype none
module pcintu_sva
  import pcintu_pkg::*;
(
  // clock and reset
  input wire logic               hclk,
  input wire logic               hresetn,
  // bus
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [DATA_W-1:0]  hrdata,
  // pins and core side
  input wire logic [GRP0_W-1:0]  watched_pins_group0,
  input wire logic [GRP1_W-1:0]  watched_pins_group1,
  input wire logic [GRP2_W-1:0]  watched_pins_group2,
  input wire logic [NUM_GRP-1:0] group_vector_req,
  input wire logic [NUM_GRP-1:0] group_vector_ack,
  input wire logic               irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // all pins side by side
  wire logic [22:0] pa = {watched_pins_group2, watched_pins_group1, watched_pins_group0};
  logic             wr_q;
  // write in its data phase, register lands at the next edge
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= hsel & hready & htrans[1] & hwrite;
  // causes of a rising request: a landed write or a pin change three edges back
  sequence wr_s; $past(wr_q); endsequence
  sequence c0_s; $past(pa[7:0], 3) != $past(pa[7:0], 4); endsequence
  sequence c2_s; $past(pa[22:15], 3) != $past(pa[22:15], 4); endsequence
  sequence ca_s; $past(pa, 3) != $past(pa, 4); endsequence
  rise_g0_a: assert property ($rose(group_vector_req[0]) |-> (c0_s or wr_s))
    else $error("group 0 request rose without cause");
  rise_g2_a: assert property ($rose(group_vector_req[2]) |-> (c2_s or wr_s))
    else $error("group 2 request rose without cause");
  ack_clr0_a: assert property (group_vector_ack[0] && $past(pa[7:0], 2) == $past(pa[7:0], 3)
    |=> !group_vector_req[0]) else $error("group 0 request kept after ack");
  ack_clr2_a: assert property (group_vector_ack[2] && $past(pa[22:15], 2) == $past(pa[22:15], 3)
    |=> !group_vector_req[2]) else $error("group 2 request kept after ack");
  hold_g0_a: assert property (group_vector_req[0] && !group_vector_ack[0] && !wr_q
    |=> group_vector_req[0]) else $error("group 0 request dropped alone");
  hold_g2_a: assert property (group_vector_req[2] && !group_vector_ack[2] && !wr_q
    |=> group_vector_req[2]) else $error("group 2 request dropped alone");
  irq_rise_a: assert property ($rose(irq) |-> (ca_s or wr_s))
    else $error("irq rose without cause");
  upper_zero_a: assert property (hrdata[DATA_W-1:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule
bind pcintu_core pcintu_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .watched_pins_group0(watched_pins_group0), .watched_pins_group1(watched_pins_group1),
  .watched_pins_group2(watched_pins_group2), .group_vector_req(group_vector_req),
  .group_vector_ack(group_vector_ack), .irq(irq));
`default_nettype wire

/* tb/pcintu_pins.sv */
// model of the off-chip signals on the watched pins
`timescale 1ns/100ps
`default_nettype none
module pcintu_pins
  import pcintu_pkg::*;
(
  // clock and toggle requests
  input wire logic    hclk,
  input wire logic [22:0] tgl,
  // pin levels, held steady between toggles
  output logic [GRP0_W-1:0] p0,
  output logic [GRP1_W-1:0] p1,
  output logic [GRP2_W-1:0] p2
);
  initial {p2, p1, p0} = 23'h0;
  // a pin flips one edge after its toggle is asked for
  always @(posedge hclk)
    {p2, p1, p0} <= {p2, p1, p0} ^ tgl;
endmodule
`default_nettype wire

/* tb/tb_pin_change_interrupt_unit.sv */
// self-checking bench for the pin change interrupt unit
`timescale 1ns/100ps
`default_nettype none
module tb_pin_change_interrupt_unit
  import pcintu_pkg::*;
;
  logic              hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [DATA_W-1:0] haddr = '0, hwdata = '0, hrdata, q;
  logic              hreadyout, hresp, irq;
  logic [22:0]       tg = '0;
  logic [7:0]        p0, p2;
  logic [6:0]        p1;
  logic [2:0]        req, ack = 3'h0;
  logic [7:0]        ix [5] = '{IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_GRP_EN, 8'h80};
  logic [31:0]       ex [5] = '{32'hFF, 32'h7F, 32'hFF, 32'h07, 32'h00};
  int                mismatches = 0, n_checks = 0;
  always #4 hclk = ~hclk;
  pcintu_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .watched_pins_group0(p0),
    .watched_pins_group1(p1), .watched_pins_group2(p2), .group_vector_req(req),
    .group_vector_ack(ack), .irq(irq));
  pcintu_pins u_pins (.hclk(hclk), .tgl(tg), .p0(p0), .p1(p1), .p2(p2));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // wait for hready under a bound
  task automatic wt;
    int n;
    @(posedge hclk);
    for (n = 0; hreadyout !== 1'b1 && n < 64; n++) @(posedge hclk);
    if (n >= 64)
    begin
      mismatches++;
      report_and_stop;
    end
  endtask
  task automatic bus(input logic [7:0] i, input logic w, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    bus(i, 1'b0, 32'h0);
    chk($sformatf("reg %h", i), e, q);
  endtask
  // flip pins, then let them cross the synchroniser
  task automatic tog(input logic [22:0] v);
    tg <= v;
    @(posedge hclk);
    tg <= 23'h0;
    repeat (6) @(posedge hclk);
  endtask
  task automatic outs(input logic [2:0] r, input logic i);
    @(negedge hclk);
    chk("req", {29'h0, r}, {29'h0, req});
    chk("irq", {31'h0, i}, {31'h0, irq});
    @(posedge hclk);
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ix[k]) rd(ix[k], 32'h0);
    foreach (ix[k]) bus(ix[k], 1'b1, 32'hFFFF_FFFF);
    foreach (ix[k]) rd(ix[k], ex[k]);
    bus(IDX_MASK0, 1'b1, 32'h01);
    bus(IDX_MASK1, 1'b1, 32'h40);
    bus(IDX_MASK2, 1'b1, 32'h80);
    tog({8'h7F, 7'h3F, 8'hFE});
    rd(IDX_GRP_FLG, 32'h0);
    tog({8'h00, 7'h00, 8'h01});
    rd(IDX_GRP_FLG, 32'h1);
    outs(3'h0, 1'b0);
    tog({8'h80, 7'h40, 8'h00});
    rd(IDX_GRP_FLG, 32'h7);
    bus(IDX_CORE_ST, 1'b1, 32'h80);
    outs(3'h7, 1'b0);
    bus(IDX_GRP_EN, 1'b1, 32'h5);
    outs(3'h5, 1'b0);
    ack <= 3'h5;
    @(posedge hclk);
    ack <= 3'h0;
    rd(IDX_GRP_FLG, 32'h2);
    bus(IDX_GRP_FLG, 1'b1, 32'h2);
    rd(IDX_GRP_FLG, 32'h0);
    rd(IDX_EVT_ST, 32'h7);
    bus(IDX_EVT_EN, 1'b1, 32'h1);
    outs(3'h0, 1'b1);
    bus(IDX_EVT_CLR, 1'b1, 32'h1);
    rd(IDX_EVT_ST, 32'h6);
    outs(3'h0, 1'b0);
    rd(IDX_EVT_CLR, 32'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
